// ==== design/core_ops.v ====
// Execution unit for a subset of an 8-bit core, reached over AXI4-Lite.
// Assumes a single clock; the halt output gates the core clock outside.
`timescale 1ns/1ps
`include "core_ops_defines.vh"

module core_ops #(
  parameter FILE_DEPTH = 32,
  parameter WATCHDOG_WIDTH = 8,
  parameter PRESCALE_WIDTH = 8
) (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire wake,
  input wire pin_change_wake_flag,
  output reg halted,
  output reg oscillator_run,
  output reg [7:0] direction_low,
  output reg [7:0] direction_high
);

  // ****************************************************************
  // State
  // ****************************************************************
  reg [7:0] file_reg [0:FILE_DEPTH-1];
  reg [7:0] acc;
  reg [7:0] status;
  reg [WATCHDOG_WIDTH-1:0] watchdog_counter;
  reg [PRESCALE_WIDTH-1:0] prescaler;
  reg aw_held;
  reg [7:0] aw_addr;
  reg w_held;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  integer i;

  wire [7:0] alu_result;
  wire [7:0] alu_status;
  wire [3:0] cmd_op;
  wire [4:0] cmd_addr;
  wire cmd_dest;
  wire [7:0] cmd_lit;
  wire [7:0] cmd_operand;
  wire do_write;
  wire is_cmd;
  wire file_hit;
  wire [4:0] file_index;

  // ****************************************************************
  // Address decode
  // ****************************************************************
  // The file window is decoded the same way for writes and reads.
  function is_file_addr;
    input [7:0] a;
    begin
      is_file_addr = a[7] && (a[1:0] == 2'h0);
    end
  endfunction

  // ****************************************************************
  // Write channel capture
  // ****************************************************************
  // Address and data are held independently so either may come first.
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign do_write = aw_held && w_held && !s_axi_bvalid;

  // Command word fields.
  assign is_cmd = (aw_addr == `REG_CMD);
  assign cmd_op = w_data[`CMD_OP_LSB+3:`CMD_OP_LSB];
  assign cmd_addr = w_data[`CMD_ADDR_LSB+4:`CMD_ADDR_LSB];
  assign cmd_dest = w_data[`CMD_DEST_BIT];
  assign cmd_lit = w_data[`CMD_LIT_LSB+7:`CMD_LIT_LSB];
  // The literal form takes its operand from the command, others from the file.
  assign cmd_operand = (cmd_op == `OP_XOR_LITERAL) ? cmd_lit : file_reg[cmd_addr];

  // A file register window of 32 words sits at a fixed base.
  assign file_hit = is_file_addr(aw_addr);
  assign file_index = aw_addr[6:2];

  core_alu u_alu (
    .op(cmd_op),
    .acc(acc),
    .operand(cmd_operand),
    .status_in(status),
    .result(alu_result),
    .status_out(alu_status)
  );

  // Holding registers for the write address and data channels.
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (do_write) begin
        w_held <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Execution and register writes
  // ****************************************************************
  // A command executes in the cycle its write completes. Commands need the
  // low byte lane; a partial write without it is answered but not executed.
  always @(posedge aclk) begin
    if (!aresetn) begin
      acc <= 8'h00;
      status <= `RST_STATUS;
      watchdog_counter <= {WATCHDOG_WIDTH{1'b0}};
      prescaler <= {PRESCALE_WIDTH{1'b0}};
      halted <= 1'b0;
      oscillator_run <= 1'b1;
      direction_low <= `RST_DIR;
      direction_high <= `RST_DIR;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `AXI_OKAY;
      for (i = 0; i < FILE_DEPTH; i = i + 1) begin
        file_reg[i] <= 8'h00;
      end
    end else begin
      // The watchdog is only modelled as a free counter for halt to clear.
      if (!halted) begin
        prescaler <= prescaler + {{(PRESCALE_WIDTH-1){1'b0}}, 1'b1};
        if (&prescaler) begin
          watchdog_counter <= watchdog_counter + {{(WATCHDOG_WIDTH-1){1'b0}}, 1'b1};
        end
      end
      if (halted && wake) begin
        halted <= 1'b0;
        oscillator_run <= 1'b1;
      end
      // The wake flag is owned outside; it is mirrored, never changed here.
      status[`ST_WAKE] <= pin_change_wake_flag; // RULE2
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `AXI_OKAY;
        if (is_cmd && w_strb[0] && !halted) begin
          case (cmd_op)
            `OP_HALT: begin
              watchdog_counter <= {WATCHDOG_WIDTH{1'b0}}; // RULE1
              prescaler <= {PRESCALE_WIDTH{1'b0}}; // RULE1
              status[`ST_TIME_OUT] <= alu_status[`ST_TIME_OUT]; // RULE2
              status[`ST_POWER_DOWN] <= alu_status[`ST_POWER_DOWN]; // RULE2
              halted <= 1'b1; // RULE3
              oscillator_run <= 1'b0; // RULE3
            end
            `OP_DIRECTION: begin
              // Only selectors six and seven name a direction register.
              if (cmd_addr[2:0] == `DIR_SEL_LOW && cmd_addr[4:3] == 2'h0) begin
                direction_low <= acc; // RULE8
              end else if (cmd_addr[2:0] == `DIR_SEL_HIGH && cmd_addr[4:3] == 2'h0) begin
                direction_high <= acc; // RULE8
              end
            end
            `OP_XOR_LITERAL: begin
              acc <= alu_result; // RULE9
              status[`ST_ZERO] <= alu_status[`ST_ZERO]; // RULE9
            end
            `OP_ROTATE_LEFT, `OP_ROTATE_RIGHT, `OP_SUBTRACT, `OP_SWAP,
            `OP_XOR_REGISTER: begin
              status[2:0] <= alu_status[2:0]; // RULE4 RULE5 RULE6 RULE7 RULE10
              if (cmd_dest) begin
                file_reg[cmd_addr] <= alu_result; // RULE11
              end else begin
                acc <= alu_result; // RULE11
              end
            end
            default: begin
              s_axi_bresp <= `AXI_SLVERR;
            end
          endcase
        end else if (aw_addr == `REG_ACC) begin
          if (w_strb[0]) begin
            acc <= w_data[7:0];
          end
        end else if (aw_addr == `REG_STATUS) begin
          if (w_strb[0]) begin
            status[2:0] <= w_data[2:0];
          end
        end else if (file_hit) begin
          if (w_strb[0]) begin
            file_reg[file_index] <= w_data[7:0];
          end
        end else if (!is_cmd) begin
          s_axi_bresp <= `AXI_SLVERR;
        end else if (halted) begin
          // Commands are refused while the core sleeps.
          s_axi_bresp <= `AXI_SLVERR;
        end
      end
    end
  end

  // ****************************************************************
  // Read channel
  // ****************************************************************
  assign s_axi_arready = !s_axi_rvalid;

  // Reads answer one cycle after the address is taken.
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `AXI_OKAY;
    end else begin
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `AXI_OKAY;
        s_axi_rdata <= 32'h0000_0000;
        if (is_file_addr(s_axi_araddr)) begin
          s_axi_rdata <= {24'h000000, file_reg[s_axi_araddr[6:2]]};
        end else begin
          case (s_axi_araddr)
            `REG_CMD: s_axi_rdata <= 32'h0000_0000;
            `REG_ACC: s_axi_rdata <= {24'h000000, acc};
            `REG_STATUS: s_axi_rdata <= {24'h000000, status};
            `REG_DIR_LOW: s_axi_rdata <= {24'h000000, direction_low};
            `REG_DIR_HIGH: s_axi_rdata <= {24'h000000, direction_high};
            `REG_WATCHDOG: begin
              s_axi_rdata <= {{(32-WATCHDOG_WIDTH){1'b0}}, watchdog_counter};
            end
            `REG_STATE: s_axi_rdata <= {30'h0, oscillator_run, halted};
            default: s_axi_rresp <= `AXI_SLVERR;
          endcase
        end
      end
    end
  end

endmodule

// ==== design/core_ops_defines.vh ====
// Constants for the core-ops execution subset: opcodes, field positions,
// status bit positions, reset values and the AXI4-Lite register map.
// Assumes inclusion by bare name from the design modules.
//
// Contract
// [RULE1] Halt clears watchdog counter and prescaler.
// [RULE2] Halt sets time-out, clears power-down, keeps wake.
// [RULE3] Halt enters low power, oscillator stopped.
// [RULE4] Rotate left through carry, only carry changes.
// [RULE5] Rotate right through carry, only carry changes.
// [RULE6] Subtract accumulator from register, update C DC Z.
// [RULE7] Nibble swap, no flags change.
// [RULE8] Direction load copies accumulator, register six or seven.
// [RULE9] XOR literal into accumulator, update zero.
// [RULE10] XOR register with accumulator, update zero only.
// [RULE11] Destination bit zero accumulator, one register.
// [RULE12] Zero flag on zero result; carry means no borrow.
`ifndef CORE_OPS_DEFINES_VH
`define CORE_OPS_DEFINES_VH

// ****************************************************************
// Operation codes
// ****************************************************************
`define OP_NONE 4'h0
`define OP_HALT 4'h1
`define OP_ROTATE_LEFT 4'h2
`define OP_ROTATE_RIGHT 4'h3
`define OP_SUBTRACT 4'h4
`define OP_SWAP 4'h5
`define OP_DIRECTION 4'h6
`define OP_XOR_LITERAL 4'h7
`define OP_XOR_REGISTER 4'h8

// ****************************************************************
// Status bit positions and direction register selectors
// ****************************************************************
`define ST_CARRY 0
`define ST_DIGIT 1
`define ST_ZERO 2
`define ST_POWER_DOWN 3
`define ST_TIME_OUT 4
`define ST_WAKE 7
`define DIR_SEL_LOW 3'h6
`define DIR_SEL_HIGH 3'h7

// ****************************************************************
// Register map (byte addresses) and reset values
// ****************************************************************
`define REG_CMD 8'h00
`define REG_ACC 8'h04
`define REG_STATUS 8'h08
`define REG_FILE_BASE 8'h80
`define REG_DIR_LOW 8'h0c
`define REG_DIR_HIGH 8'h10
`define REG_WATCHDOG 8'h14
`define REG_STATE 8'h18
`define RST_STATUS 8'h18
`define RST_DIR 8'hff
`define CMD_OP_LSB 0
`define CMD_ADDR_LSB 4
`define CMD_DEST_BIT 9
`define CMD_LIT_LSB 16
`define AXI_OKAY 2'h0
`define AXI_SLVERR 2'h2

`endif

// ==== design/core_alu.v ====
// Combinational result and flag computation for one operation.
// Assumes operands are stable while the caller samples the result.
`timescale 1ns/1ps
`include "core_ops_defines.vh"

module core_alu (
  input wire [3:0] op,
  input wire [7:0] acc,
  input wire [7:0] operand,
  input wire [7:0] status_in,
  output reg [7:0] result,
  output reg [7:0] status_out
);

  // ****************************************************************
  // Zero test
  // ****************************************************************
  function is_zero;
    input [7:0] v;
    begin
      is_zero = (v == 8'h00); // RULE12
    end
  endfunction

  reg [8:0] diff;
  reg [4:0] low_diff;

  // Each operation touches only its own flags; the rest pass through.
  always @* begin
    result = operand;
    status_out = status_in;
    diff = {1'b0, operand} + {1'b0, ~acc} + 9'h001;
    low_diff = {1'b0, operand[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;
    case (op)
      `OP_ROTATE_LEFT: begin
        result = {operand[6:0], status_in[`ST_CARRY]}; // RULE4
        status_out[`ST_CARRY] = operand[7]; // RULE4
      end
      `OP_ROTATE_RIGHT: begin
        result = {status_in[`ST_CARRY], operand[7:1]}; // RULE5
        status_out[`ST_CARRY] = operand[0]; // RULE5
      end
      `OP_SUBTRACT: begin
        result = diff[7:0]; // RULE6
        status_out[`ST_CARRY] = diff[8]; // RULE12
        status_out[`ST_DIGIT] = low_diff[4]; // RULE6
        status_out[`ST_ZERO] = is_zero(diff[7:0]); // RULE6
      end
      `OP_SWAP: begin
        result = {operand[3:0], operand[7:4]}; // RULE7
      end
      `OP_XOR_LITERAL, `OP_XOR_REGISTER: begin
        result = acc ^ operand; // RULE9 RULE10
        status_out[`ST_ZERO] = is_zero(acc ^ operand); // RULE12
      end
      `OP_HALT: begin
        status_out[`ST_TIME_OUT] = 1'b1; // RULE2
        status_out[`ST_POWER_DOWN] = 1'b0; // RULE2
      end
      default: begin
        result = operand;
      end
    endcase
  end

endmodule

// ==== tb/core_ops_checker.sv ====
// Concurrent checks on the core-ops block ports: bus answers, halt, direction.
// Assumes binding to core_ops; sees only its ports.
`timescale 1ns/1ps
module core_ops_checker (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_bvalid,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire wake,
  input wire halted,
  input wire oscillator_run,
  input wire [7:0] direction_low,
  input wire [7:0] direction_high
);
  // ****************************************************************
  // Properties
  // ****************************************************************
  // All checks live in the one clock domain, so clocking is set once.
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  osc_stopped_a: assert property (oscillator_run == !halted)
    else $error("oscillator state disagrees with halt");
  halt_by_cmd_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(halted) |-> $rose(s_axi_bvalid) && s_axi_bresp == 2'h0)
    else $error("halt entered without a completed command");
  wake_leaves_a: assert property (halted && wake |=> !halted)
    else $error("wake did not leave halt");
  dir_low_cmd_a: assert property (!$stable(direction_low) |-> $rose(s_axi_bvalid))
    else $error("low direction changed outside a command");
  dir_high_cmd_a: assert property (!$stable(direction_high) |-> $rose(s_axi_bvalid))
    else $error("high direction changed outside a command");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered in one cycle");
  write_answer_a: assert property (s_axi_awvalid && s_axi_awready |-> ##[1:40] s_axi_bvalid)
    else $error("write not answered");
  read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while answer pending");
endmodule

bind core_ops core_ops_checker i_core_ops_checker (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_bvalid, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .wake, .halted, .oscillator_run, .direction_low, .direction_high);

// ==== tb/baseline_core_ops_subset_tb_top.sv ====
// Self-checking bench for the core-ops block, driven over AXI4-Lite.
// Assumes the design defines header is on the include path.
`timescale 1ns/1ps
`include "core_ops_defines.vh"
module baseline_core_ops_subset_tb_top;
  reg aclk, aresetn, wake, pin_change_wake_flag;
  reg [7:0] s_axi_awaddr, s_axi_araddr;
  reg [31:0] s_axi_wdata, seed, rd;
  reg s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  reg [1:0] rsp;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire halted, oscillator_run;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [7:0] direction_low, direction_high;
  integer miscompares, check_count, i, n, acc, fl, st, r, k, d, op, dl, dh;

  core_ops i_core_ops (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .wake, .pin_change_wake_flag, .halted, .oscillator_run,
    .direction_low, .direction_high);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Prints the verdict and ends the run; the only exit of the bench.
  task close_out;
    begin
      if (miscompares == 0 && check_count > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      check_count++;
      if (e !== g) begin
        miscompares++;
        $display("[ERR] %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task tmo;
    begin
      miscompares++;
      $display("[ERR] bus wait expected answer seen none");
      close_out;
    end
  endtask
  // Offers address and data together and drops each once taken.
  task wchk(input [7:0] a, input [31:0] dat, input [1:0] er);
    integer t;
    begin
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= dat;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (t = 0; t < 60; t++) begin
        @(posedge aclk);
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
        if (s_axi_bvalid) break;
      end
      rsp = s_axi_bresp;
      s_axi_bready <= 1'b0;
      if (t == 60) tmo;
      chk("bresp", er, rsp);
    end
  endtask
  task rchk(input string nm, input [7:0] a, input [31:0] e);
    integer t;
    begin
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (t = 0; t < 60; t++) begin
        @(posedge aclk);
        if (s_axi_arready) s_axi_arvalid <= 1'b0;
        if (s_axi_rvalid) break;
      end
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
      s_axi_rready <= 1'b0;
      if (t == 60) tmo;
      chk(nm, e, rd);
    end
  endtask
  function [31:0] rnd();
    begin
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      rnd = seed;
    end
  endfunction

  // ****************************************************************
  // Clock and sequence
  // ****************************************************************
  // A 100 ns period clock.
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  // Each pass loads operands, runs one operation and compares with the model.
  initial begin
    seed = 32'h95c1;
    miscompares = 0;
    check_count = 0;
    {aresetn, wake, pin_change_wake_flag, s_axi_awvalid, s_axi_wvalid} = 5'h0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 19'h0;
    s_axi_wdata = 32'h0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    chk("dir_low", 8'hff, direction_low);
    rchk("status", `REG_STATUS, 32'h18);
    rchk("unmapped", 8'h40, 32'h0);
    chk("rresp", `AXI_SLVERR, rsp);
    wchk(8'h44, 32'h5, `AXI_SLVERR);
    st = 8'h18;
    dl = 255;
    dh = 255;
    for (i = 0; i < 42; i++) begin
      op = 2 + i % 7;
      n = rnd() & 31;
      acc = rnd() & 255;
      fl = (i % 3 == 0) ? acc : rnd() & 255;
      k = (i % 3 == 0) ? acc : rnd() & 255;
      d = (i / 7) % 2;
      if (op == 6) n = (i % 3 == 1) ? 5 : 6 + d;
      st = (st & 8'hf8) | (rnd() & 7);
      wchk(`REG_FILE_BASE + 4 * n, fl, `AXI_OKAY);
      wchk(`REG_ACC, acc, `AXI_OKAY);
      wchk(`REG_STATUS, st, `AXI_OKAY);
      case (op)
        2: begin r = ((fl << 1) | (st & 1)) & 255; st = (st & ~1) | (fl >> 7); end
        3: begin r = (fl >> 1) | ((st & 1) << 7); st = (st & ~1) | (fl & 1); end
        4: begin r = (fl - acc) & 255; st = (st & 8'hf8) | (fl >= acc)
             | (((fl & 15) >= (acc & 15)) << 1) | ((r == 0) << 2); end
        5: r = ((fl & 15) << 4) | (fl >> 4);
        6: begin if (n == 6) dl = acc; if (n == 7) dh = acc; end
        7: begin acc = acc ^ k; st = (st & ~4) | ((acc == 0) << 2); end
        default: begin r = acc ^ fl; st = (st & ~4) | ((r == 0) << 2); end
      endcase
      if (op < 6 || op == 8) begin if (d) fl = r; else acc = r; end
      wchk(`REG_CMD, (k << 16) | (d << 9) | (n << 4) | op, `AXI_OKAY);
      rchk("acc", `REG_ACC, acc);
      rchk("file", `REG_FILE_BASE + 4 * n, fl);
      rchk("status", `REG_STATUS, st);
      chk("dir_low", dl, direction_low);
      chk("dir_high", dh, direction_high);
    end
    // Unknown opcodes are refused and leave the accumulator alone.
    wchk(`REG_CMD, 32'h9, `AXI_SLVERR);
    wchk(`REG_CMD, 32'h0, `AXI_SLVERR);
    rchk("acc", `REG_ACC, acc);
    // Let the watchdog move first, so that clearing it is visible.
    repeat (600) @(posedge aclk);
    pin_change_wake_flag <= 1'b1;
    wchk(`REG_CMD, `OP_HALT, `AXI_OKAY);
    rchk("status", `REG_STATUS, (st & 8'h07) | 8'h90);
    rchk("watchdog", `REG_WATCHDOG, 32'h0);
    rchk("state", `REG_STATE, 32'h1);
    chk("osc", 1'b0, oscillator_run);
    wchk(`REG_CMD, `OP_XOR_LITERAL | 32'h00ff0000, `AXI_SLVERR);
    rchk("acc", `REG_ACC, acc);
    wake <= 1'b1;
    @(posedge aclk);
    wake <= 1'b0;
    @(posedge aclk);
    chk("halted", 1'b0, halted);
    close_out;
  end
endmodule
